/* inc/keypad_pkg.sv */
package keypad_pkg;
    // register byte addresses (printed offsets are not all multiples of four)
    localparam logic [11:0] IDX_STATUS_CONTROL = 12'h01A;
    localparam logic [11:0] IDX_PIN_ENABLE = 12'h01B;
    localparam logic [11:0] IDX_PIN_POLARITY = 12'h448;
    localparam logic [13:0] ADDR_STATUS_CONTROL = {IDX_STATUS_CONTROL, 2'b00};
    localparam logic [13:0] ADDR_PIN_ENABLE = {IDX_PIN_ENABLE, 2'b00};
    localparam logic [13:0] ADDR_PIN_POLARITY = {IDX_PIN_POLARITY, 2'b00};
    // status/control field positions
    localparam int BIT_SENSITIVITY = 0;
    localparam int BIT_MASK = 1;
    localparam int BIT_ACK = 2;
    localparam int BIT_PENDING = 3;
    // reset values
    localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
    localparam logic [7:0] RST_PIN_POLARITY = 8'h00;
    localparam logic RST_MASK = 1'b0;
    localparam logic RST_SENSITIVITY = 1'b0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one read answer
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_answer_s;
endpackage

/* src/keypad_interrupt_unit.sv */
// Operation
// - edge-only mode: new edge ignored while another enabled pin is asserted
// - edge-and-level mode: request present while any enabled pin asserted
// - level mode: clear needs acknowledge and all pins deasserted, either order
// - vector fetch makes an acknowledge pulse on the request latch
// - writing one to acknowledge bit acts like a vector fetch
// - an edge after acknowledge latches a fresh request
// - unmasked latched request goes to cpu, vector at FFE0/FFE1
// - edge-only mode: acknowledge clears the request at once
// - reset clears request and sensitivity select even with pin asserted
// - pending flag shows request regardless of mask
// - enabled pin forced to input, direction bit still needed to read
// - polarity bit with sensitivity select picks edge and level sense
// - detection continues in wait and stop; unmasked request wakes cpu
// - break clear enabled: acknowledge in break clears latch for good
// - break clear disabled: acknowledge bit write in break has no effect
// - status/control at 1A: pending bit3, ack bit2, mask bit1, select bit0
// - enable at 1B and polarity at 448, one bit per pin, reset zero
// - polarity one means rising/high, zero means falling/low
// - edge is deasserted one bus cycle then asserted the next
// - mask stops cpu request without clearing latch; reset clears mask
//
// Local design decision: the AXI4-Lite interface to the registers.
module keypad_interrupt_unit #(
    parameter int NUM_PINS = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // key pins and system
    input wire logic [NUM_PINS-1:0] key_pins,
    input wire logic vector_fetch,
    input wire logic break_state,
    input wire logic break_clear_enable,
    // cpu side
    output logic cpu_irq,
    output logic wake_request,
    output logic [NUM_PINS-1:0] pin_force_input
);

    logic [NUM_PINS-1:0] pin_enable_r;
    logic [NUM_PINS-1:0] pin_polarity_r;
    logic mask_r;
    logic sense_r;
    logic pending_r;
    logic [NUM_PINS-1:0] sync1_r;
    logic [NUM_PINS-1:0] sync2_r;
    logic [NUM_PINS-1:0] asserted_prev_r;
    logic vf_d_r;
    logic [NUM_PINS-1:0] asserted;
    logic [NUM_PINS-1:0] edge_hit;
    logic any_asserted;
    logic any_edge;
    logic vf_pulse;
    logic sw_ack;
    logic ack;
    logic pending_nxt;
    logic acked_r;
    logic acked_nxt;
    logic wr_fire;
    logic aw_held_r;
    logic w_held_r;
    logic [13:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    keypad_pkg::rd_answer_s rd_ans;

    // two-flop pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= key_pins;
            sync2_r <= sync1_r;
        end
    end

    // per-pin assertion and edge detection
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            // polarity one senses high, zero senses low
            assign asserted[g] = pin_enable_r[g] & (sync2_r[g] == pin_polarity_r[g]);
            // deasserted one cycle, asserted the next
            assign edge_hit[g] = asserted[g] & ~asserted_prev_r[g];
        end
    endgenerate

    // previous sampled assertion state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            asserted_prev_r <= '0;
        end else begin
            asserted_prev_r <= asserted;
        end
    end

    // an edge counts only if no other enabled pin was already asserted
    assign any_edge = |(edge_hit) && ((asserted_prev_r & ~edge_hit) == '0);
    assign any_asserted = |asserted;

    // vector fetch to single-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vf_d_r <= 1'b0;
        end else begin
            vf_d_r <= vector_fetch;
        end
    end
    assign vf_pulse = vector_fetch & ~vf_d_r;

    // software acknowledge, blocked in break unless clear enabled
    assign sw_ack = wr_fire && awaddr_r == keypad_pkg::ADDR_STATUS_CONTROL && wstrb_r[0]
        && wdata_r[keypad_pkg::BIT_ACK] && (!break_state || break_clear_enable);
    assign ack = vf_pulse | sw_ack;

    // request latch: set wins over acknowledge
    always_comb begin
        pending_nxt = pending_r;
        acked_nxt = acked_r;
        if (ack) begin
            acked_nxt = 1'b1;
        end
        // edge-only: acknowledge clears at once
        if (!sense_r && ack) begin
            pending_nxt = 1'b0;
        end
        // level mode: clear once acknowledged and all enabled pins released
        if (sense_r && acked_nxt && !any_asserted) begin
            pending_nxt = 1'b0;
        end
        // a fresh edge latches again and wants a new acknowledge
        if (any_edge) begin
            pending_nxt = 1'b1;
            acked_nxt = 1'b0;
        end
        if (!pending_nxt) begin
            acked_nxt = 1'b0;
        end
    end

    // pending state, cleared by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_r <= 1'b0;
            acked_r <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
            acked_r <= acked_nxt;
        end
    end

    // cpu request gated by mask only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_irq <= 1'b0;
            wake_request <= 1'b0;
            pin_force_input <= '0;
        end else begin
            cpu_irq <= pending_nxt & ~mask_r;
            wake_request <= pending_nxt & ~mask_r;
            pin_force_input <= pin_enable_r;
        end
    end

    // write address and data capture, either order
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            // each ready drops when its item is taken, returns after the response
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end
    // register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_enable_r <= keypad_pkg::RST_PIN_ENABLE;
            pin_polarity_r <= keypad_pkg::RST_PIN_POLARITY;
            mask_r <= keypad_pkg::RST_MASK;
            sense_r <= keypad_pkg::RST_SENSITIVITY;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= keypad_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= keypad_pkg::RESP_OKAY;
                case (awaddr_r)
                    keypad_pkg::ADDR_STATUS_CONTROL: begin
                        if (wstrb_r[0]) begin
                            mask_r <= wdata_r[keypad_pkg::BIT_MASK];
                            sense_r <= wdata_r[keypad_pkg::BIT_SENSITIVITY];
                        end
                    end
                    keypad_pkg::ADDR_PIN_ENABLE: begin
                        if (wstrb_r[0]) begin
                            pin_enable_r <= wdata_r[NUM_PINS-1:0];
                        end
                    end
                    keypad_pkg::ADDR_PIN_POLARITY: begin
                        if (wstrb_r[0]) begin
                            pin_polarity_r <= wdata_r[NUM_PINS-1:0];
                        end
                    end
                    default: begin
                        s_axi_bresp <= keypad_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read decode; ack bit and upper bits read zero
    always_comb begin
        rd_ans.data = '0;
        rd_ans.resp = keypad_pkg::RESP_OKAY;
        case (s_axi_araddr)
            keypad_pkg::ADDR_STATUS_CONTROL: begin
                rd_ans.data[keypad_pkg::BIT_PENDING] = pending_r;
                rd_ans.data[keypad_pkg::BIT_MASK] = mask_r;
                rd_ans.data[keypad_pkg::BIT_SENSITIVITY] = sense_r;
            end
            keypad_pkg::ADDR_PIN_ENABLE: rd_ans.data[NUM_PINS-1:0] = pin_enable_r;
            keypad_pkg::ADDR_PIN_POLARITY: rd_ans.data[NUM_PINS-1:0] = pin_polarity_r;
            default: rd_ans.resp = keypad_pkg::RESP_SLVERR;
        endcase
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= keypad_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ans.data;
            s_axi_rresp <= rd_ans.resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    a_edge_sets_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        any_edge |=> pending_r) else $error("edge did not latch request");
    a_level_holds_req: assert property (@(posedge aclk) disable iff (!aresetn)
        (sense_r && pending_r && any_asserted) |=> pending_r)
        else $error("level request dropped");
    a_edge_only_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (!sense_r && ack && !any_edge) |=> !pending_r)
        else $error("ack did not clear");
    a_level_needs_both: assert property (@(posedge aclk) disable iff (!aresetn)
        (!pending_r && $past(pending_r) && $past(sense_r))
        |-> (($past(ack) || $past(acked_r)) && !$past(any_asserted)))
        else $error("level clear without both conditions");
    a_break_protects: assert property (@(posedge aclk) disable iff (!aresetn)
        (pending_r && break_state && !break_clear_enable && !vf_pulse) |=> pending_r)
        else $error("ack in break cleared latch");
    a_mask_gates_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (mask_r && $stable(mask_r)) |=> !cpu_irq) else $error("masked irq seen");
    a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (pending_r && !mask_r && $stable(mask_r)) |-> cpu_irq)
        else $error("unmasked request not sent");
    a_blocked_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        (!sense_r && !pending_r && !ack && |edge_hit && |(asserted_prev_r & ~edge_hit))
        |=> !pending_r) else $error("edge latched while other pin held");
    a_vf_single: assert property (@(posedge aclk) disable iff (!aresetn)
        vf_pulse |=> !vf_pulse) else $error("fetch ack longer than a cycle");
    c_edge_irq: cover property (@(posedge aclk) disable iff (!aresetn) any_edge ##2 cpu_irq);
    c_sw_ack: cover property (@(posedge aclk) disable iff (!aresetn) pending_r ##1 sw_ack);
    c_level_hold: cover property (@(posedge aclk) disable iff (!aresetn)
        sense_r && ack && any_asserted ##1 pending_r);
    a_level_release: assert property (@(posedge aclk) disable iff (!aresetn)
        (sense_r && acked_r && pending_r && !any_asserted) |=> !pending_r)
        else $error("acknowledged level request not cleared on release");
    a_sw_ack_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (!sense_r && sw_ack && !any_edge) |=> !pending_r) else $error("write ack did not clear");
    a_wake_match: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_request == cpu_irq) else $error("wake differs from cpu request");
    a_force_input: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_force_input == $past(pin_enable_r)) else $error("force input not following enable");
    a_read_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arready == !s_axi_rvalid) else $error("read ready while answer stands");
    c_break_ack: cover property (@(posedge aclk) disable iff (!aresetn) break_state && sw_ack);
    c_level_release: cover property (@(posedge aclk) disable iff (!aresetn)
        sense_r && acked_r && !any_asserted);

endmodule

/* sim/key_switches.sv */
module key_switches (
    // switch state and pull selection
    input wire logic [7:0] press,
    input wire logic [7:0] polarity,
    // pins seen by the unit
    output logic [7:0] key_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // pressed key drives its asserted level, a released key rests at its pull level
    assign key_pins = press ^ ~polarity;
endmodule

/* sim/tb_top.sv */
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %h got %h", nm, e, g); bad_count++; end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] SC = keypad_pkg::ADDR_STATUS_CONTROL;
    localparam logic [13:0] EN = keypad_pkg::ADDR_PIN_ENABLE;
    localparam logic [13:0] PO = keypad_pkg::ADDR_PIN_POLARITY;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [13:0] awaddr = '0;
    logic [13:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, cpu_irq, wake;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [7:0] press = 8'h00, pol = 8'h00, pins, force_in;
    logic vf = 1'h0, brk = 1'h0, bce = 1'h0;
    int bad_count = 0, compares = 0, seed = 66427, r;

    // 50 MHz bus clock
    always #10 aclk = ~aclk;

    keypad_interrupt_unit keypad_interrupt_unit_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .key_pins(pins), .vector_fetch(vf), .break_state(brk), .break_clear_enable(bce),
        .cpu_irq(cpu_irq), .wake_request(wake), .pin_force_input(force_in));

    key_switches key_switches_i (.press(press), .polarity(pol), .key_pins(pins));

    // expected status word
    function automatic logic [31:0] st(input logic p, input logic m, input logic s);
        return {28'h0, p, 1'h0, m, s};
    endfunction

    // one axi write, address and data offered together
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 50);
        if (bvalid !== 1'h1) begin
            bad_count++;
            finish_test;
        end
        rs = bresp;
        bready <= 1'h0;
    endtask

    // one axi read
    task automatic rdr(input logic [13:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 50);
        if (rvalid !== 1'h1) begin
            bad_count++;
            finish_test;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask

    // status word and request outputs
    task automatic chk(input logic p, input logic m, input logic s);
        rdr(SC);
        `CHK("status", st(p, m, s), rd)
        `CHK("cpu_irq", p & ~m, cpu_irq)
        `CHK("wake", p & ~m, wake)
    endtask

    // let pin changes pass the synchroniser
    task automatic settle;
        repeat (6) @(posedge aclk);
    endtask

    task automatic pulse_fetch;
        vf <= 1'h1;
        @(posedge aclk);
        vf <= 1'h0;
        settle;
    endtask

    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        finish_test;
    end

    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        chk(1'h0, 1'h0, 1'h0);
        rdr(14'h0004);
        `CHK("rresp", keypad_pkg::RESP_SLVERR, rs)
        wr(14'h0004, 8'hFF);
        `CHK("bresp", keypad_pkg::RESP_SLVERR, rs)
        repeat (4) begin
            r = $random(seed);
            wr(EN, r[7:0]);
            wr(PO, r[15:8]);
            rdr(EN);
            `CHK("enable", {24'h0, r[7:0]}, rd)
            `CHK("force_in", r[7:0], force_in)
            rdr(PO);
            `CHK("polarity", {24'h0, r[15:8]}, rd)
        end
        wstrb <= 4'h0;
        wr(EN, ~r[7:0]);
        wstrb <= 4'hF;
        rdr(EN);
        `CHK("strobe", {24'h0, r[7:0]}, rd)
        // masked start-up: mask, program pins, acknowledge, unmask
        r = $random(seed);
        pol <= r[7:0];
        wr(SC, 8'h02);
        wr(PO, r[7:0]);
        wr(EN, 8'hFF);
        wr(SC, 8'h06);
        wr(SC, 8'h00);
        chk(1'h0, 1'h0, 1'h0);
        // edge-only mode on every pin
        for (int i = 0; i < 8; i++) begin
            press <= 8'h01 << i;
            settle;
            chk(1'h1, 1'h0, 1'h0);
            wr(SC, 8'h02);
            chk(1'h1, 1'h1, 1'h0);
            wr(SC, 8'h06);
            chk(1'h0, 1'h1, 1'h0);
            press <= press | (8'h01 << ((i + 1) % 8));
            settle;
            chk(1'h0, 1'h1, 1'h0);
            press <= 8'h00;
            settle;
            wr(SC, 8'h00);
        end
        // disabling a held pin lets other edges through
        press <= 8'h01;
        settle;
        wr(SC, 8'h04);
        wr(EN, 8'hFE);
        press <= 8'h03;
        settle;
        chk(1'h1, 1'h0, 1'h0);
        pulse_fetch;
        chk(1'h0, 1'h0, 1'h0);
        press <= 8'h00;
        wr(EN, 8'hFF);
        // edge-and-level mode, both clearing orders
        wr(SC, 8'h01);
        press <= 8'h10;
        settle;
        chk(1'h1, 1'h0, 1'h1);
        wr(SC, 8'h05);
        chk(1'h1, 1'h0, 1'h1);
        press <= 8'h00;
        settle;
        chk(1'h0, 1'h0, 1'h1);
        press <= 8'h20;
        settle;
        press <= 8'h00;
        settle;
        chk(1'h1, 1'h0, 1'h1);
        pulse_fetch;
        chk(1'h0, 1'h0, 1'h1);
        // acknowledge during break
        wr(SC, 8'h00);
        press <= 8'h40;
        settle;
        press <= 8'h00;
        brk <= 1'h1;
        wr(SC, 8'h04);
        chk(1'h1, 1'h0, 1'h0);
        bce <= 1'h1;
        wr(SC, 8'h04);
        brk <= 1'h0;
        bce <= 1'h0;
        chk(1'h0, 1'h0, 1'h0);
        // reset with a pin held in level mode
        wr(SC, 8'h01);
        press <= 8'h80;
        settle;
        chk(1'h1, 1'h0, 1'h1);
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        chk(1'h0, 1'h0, 1'h0);
        finish_test;
    end
endmodule
